// [inc/hut_params.svh]
/*
  Constants of the host-link UART: register offsets, field positions,
  reset values, control characters and timing figures.
  Assumes a single 100 MHz system clock; included by bare name.
*/
`ifndef HUT_PARAMS_SVH
`define HUT_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and line rates
// ----------------------------------------------------------------------
`define HUT_CLK_HZ        100000000
`define HUT_BAUD_RESET    115200
`define HUT_BAUD_MIN      9600
`define HUT_BAUD_MAX      4000000
`define HUT_DIV_RESET     (`HUT_CLK_HZ / `HUT_BAUD_RESET)
`define HUT_DIV_MIN       (`HUT_CLK_HZ / `HUT_BAUD_MAX)
`define HUT_DIV_MAX       (`HUT_CLK_HZ / `HUT_BAUD_MIN)
`define HUT_RTS_MARGIN    16

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define HUT_REG_CTRL      8'h00
`define HUT_REG_DIV       8'h04
`define HUT_REG_STATUS    8'h08
`define HUT_REG_TXDATA    8'h0C
`define HUT_REG_RXDATA    8'h10
`define HUT_REG_LEVEL     8'h14
`define HUT_CTRL_RESET    32'h0000_0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HUT_CTRL_THREE    0
`define HUT_CTRL_XON      1
`define HUT_CTRL_SLIP     2
`define HUT_CTRL_ABAUD    3
`define HUT_CTRL_SLEEP    4
`define HUT_ST_RXVALID    0
`define HUT_ST_TXFULL     1
`define HUT_ST_PAUSED     2
`define HUT_ST_WAKE       3
`define HUT_ST_ABDONE     4
`define HUT_ST_OVERRUN    5
`define HUT_ST_ABARM      6
`define HUT_DATA_EOF      8
`define HUT_DATA_VALID    9
`define HUT_LEVEL_RX      16

// ----------------------------------------------------------------------
// In-band characters
// ----------------------------------------------------------------------
`define HUT_CH_XON        8'h11
`define HUT_CH_XOFF       8'h13
`define HUT_CH_END        8'hC0
`define HUT_CH_ESC        8'hDB
`define HUT_CH_ESC_END    8'hDC
`define HUT_CH_ESC_ESC    8'hDD

`endif

// [inc/hut_pkg.sv]
/*
  Types shared by the host-link UART: buffer word and serial states.
  Assumes hut_params.svh supplies all numeric constants.
*/
package hut_pkg;

  // Buffer word: a byte plus a packet-end marker
  typedef struct packed {
    logic       eof;
    logic [7:0] data;
  } hut_word_s;

  // Serial engine states, Gray coded along the character
  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_DATA  = 2'b11,
    SER_STOP  = 2'b10
  } hut_ser_e;

endpackage

// [rtl/hut_uart.sv]
/*
  Host-link UART with transmit and receive buffers, flow control,
  SLIP assistance, line-rate detection and wake on line activity.
  Assumes one clock clk_sys, synchronous reset, and a register master
  that follows the one-cycle strobe protocol; pins are asynchronous.
*/
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`include "hut_params.svh"

// ----------------------------------------------------------------------
// Buffer with valid/ready on both sides
// ----------------------------------------------------------------------
module hut_fifo #(
  parameter  int WIDTH = 9,
  parameter  int DEPTH = 8,
  localparam int AW    = $clog2(DEPTH),
  localparam int LW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  output logic      [LW-1:0]    level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [LW-1:0]    cnt_q;

  // Pointer wrap for depths that are not a power of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Handshakes and show-ahead read
  wire push = inValid && inReady;
  wire pop  = outValid && outReady;
  assign inReady  = (cnt_q != LW'(DEPTH));
  assign outValid = (cnt_q != '0);
  assign outData  = mem[rdPtr_q];
  assign level    = cnt_q;

  // Storage, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q   <= '0;
    end else begin
      if (push) wrPtr_q <= bump(wrPtr_q);
      if (pop) rdPtr_q <= bump(rdPtr_q);
      cnt_q <= cnt_q + LW'(push) - LW'(pop);
    end
  end
endmodule // hut_fifo

// Behaviour
// - Link uses receive, transmit, request-to-send and clear-to-send lines.
// - Line rate programmable from 9600 bit/s up to 4 Mbit/s.
// - Rate detection measures host traffic and loads the divider.
// - Separate receive and transmit buffers of 1040 bytes each.
// - Both buffers reachable by the on-chip bus master.
// - After reset the link runs at 115.2 kbaud.
// - Three-wire mode ignores clear-to-send; request-to-send still follows the receive buffer level.
// - Stop and resume characters pause and restart transmission.
// - SLIP delimiting and escape substitution in hardware.
// - Asleep, activity on receive or clear-to-send raises a wake request.
// - Divider loaded by configuration or detection at any time.
// - Combined host and device rate error within two percent.
// - Divider yields close approximations of common rates.
// - Transmit starts within 1.5 bit periods of clear-to-send low.
// - Request-to-send rises within half a bit after received stop midpoint.
module hut_uart #(
  parameter int DEPTH = 1040,
  localparam int LW   = $clog2(DEPTH + 1)
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  input  wire logic        uartRxd,
  input  wire logic        uartCtsN,
  output logic             uartTxd,
  output logic             uartRtsN,
  output logic             wakeReq,
  output logic             txSpace
);
  // whole clocks per bit keep rate error small
  localparam logic [15:0]   DIV_RST = 16'(`HUT_DIV_RESET);
  localparam logic [15:0]   DIV_MIN = 16'(`HUT_DIV_MIN);
  localparam logic [15:0]   DIV_MAX = 16'(`HUT_DIV_MAX);
  localparam logic [LW-1:0] RTS_LIM = LW'(DEPTH - `HUT_RTS_MARGIN);

  logic [31:0]       ctrl_q;
  logic [15:0]       div_q;
  logic [31:0]       rdData_q;
  logic              rxMeta_q, rxSync_q, rxPrev_q;
  logic              ctsMeta_q, ctsSync_q, ctsPrev_q;
  hut_pkg::hut_ser_e txSt_q, rxSt_q;
  logic [15:0]       txCnt_q, rxCnt_q, abCnt_q;
  logic [2:0]        txBit_q, rxBit_q;
  logic [7:0]        txSh_q, rxSh_q, rxByte_q, txEscByte_q;
  logic              txd_q, txEsc_q, rxDone_q, rxEsc_q, paused_q;
  logic              rtsN_q, wake_q, abArm_q, abMeas_q, abDone_q;
  logic              overrun_q, txSpace_q;
  hut_pkg::hut_word_s txOut, rxIn;
  logic              txInReady, txOutValid, rxInReady, rxOutValid;
  logic [LW-1:0]     txLevel, rxLevel;
  hut_pkg::hut_word_s rxOut;
  logic              txPop, rxPush;

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  wire threeWire = ctrl_q[`HUT_CTRL_THREE];
  wire xonEn     = ctrl_q[`HUT_CTRL_XON];
  wire slipEn    = ctrl_q[`HUT_CTRL_SLIP];
  wire sleepEn   = ctrl_q[`HUT_CTRL_SLEEP];
  wire wrCtrl    = regWr && regAddr == `HUT_REG_CTRL;
  wire wrDiv     = regWr && regAddr == `HUT_REG_DIV;
  wire wrTx      = regWr && regAddr == `HUT_REG_TXDATA;
  wire rdStat    = regRd && regAddr == `HUT_REG_STATUS;
  wire rxPop     = regRd && regAddr == `HUT_REG_RXDATA && rxOutValid;
  wire [15:0] wrDivVal = (regWrData[15:0] < DIV_MIN) ? DIV_MIN :
                         (regWrData[15:0] > DIV_MAX) ? DIV_MAX : regWrData[15:0];
  // A stuck-low line must not push the divider past the slowest rate
  wire [15:0] abVal = (abCnt_q < DIV_MIN) ? DIV_MIN :
                      (abCnt_q > DIV_MAX) ? DIV_MAX : abCnt_q;
  wire [31:0] statWord = {25'h0, abArm_q, overrun_q, abDone_q, wake_q,
                          paused_q, !txInReady, rxOutValid};
  // Empty buffer reads as zero, never the stale head word
  wire [31:0] rxWord = rxOutValid ? {22'h0, 1'b1, rxOut.eof, rxOut.data} : 32'h0000_0000;
  wire [31:0] lvlWord = (32'(rxLevel) << `HUT_LEVEL_RX) | 32'(txLevel);
  // Unmapped offsets read as zero
  wire [31:0] rdMux =
    (regAddr == `HUT_REG_CTRL)   ? ctrl_q :
    (regAddr == `HUT_REG_DIV)    ? {16'h0000, div_q} :
    (regAddr == `HUT_REG_STATUS) ? statWord :
    (regAddr == `HUT_REG_RXDATA) ? rxWord :
    (regAddr == `HUT_REG_LEVEL)  ? lvlWord : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------------
  wire rxFall    = rxPrev_q && !rxSync_q;
  wire rxRise    = !rxPrev_q && rxSync_q;
  wire ctsChange = ctsPrev_q != ctsSync_q;
  wire ctsOk     = threeWire || !ctsSync_q;

  // Two stages per pin; the first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      {rxMeta_q, rxSync_q, rxPrev_q}    <= 3'b111;
      {ctsMeta_q, ctsSync_q, ctsPrev_q} <= 3'b111;
    end else begin
      {rxMeta_q, rxSync_q, rxPrev_q}    <= {uartRxd, rxMeta_q, rxSync_q};
      {ctsMeta_q, ctsSync_q, ctsPrev_q} <= {uartCtsN, ctsMeta_q, ctsSync_q};
    end
  end

  // ----------------------------------------------------------------------
  // Control, divider and rate detection
  // ----------------------------------------------------------------------
  // divider reloadable at any time; detection overrides the bus
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q   <= `HUT_CTRL_RESET;
      div_q    <= DIV_RST;
      abArm_q  <= 1'b0;
      abMeas_q <= 1'b0;
      abCnt_q  <= 16'h0000;
      abDone_q <= 1'b0;
    end else begin
      if (wrCtrl) ctrl_q <= regWrData & 32'h0000_0017;
      if (abArm_q && abMeas_q && rxRise) begin
        div_q    <= abVal;
        abDone_q <= 1'b1;
        abArm_q  <= 1'b0;
        abMeas_q <= 1'b0;
      end else begin
        if (wrDiv) div_q <= wrDivVal;
        if (wrCtrl && regWrData[`HUT_CTRL_ABAUD]) begin
          abArm_q  <= 1'b1;
          abDone_q <= 1'b0;
        end
        if (abArm_q && rxFall) abMeas_q <= 1'b1;
      end
      abCnt_q <= !abMeas_q ? 16'h0001 : (abCnt_q == 16'hFFFF) ? abCnt_q : abCnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------------
  // separate receive and transmit buffers
  // bus master fills and drains them
  hut_fifo #(.WIDTH(9), .DEPTH(DEPTH)) txBuf (
    .clk_sys (clk_sys),
    .reset   (reset),
    .inValid (wrTx),
    .inData  (regWrData[8:0]),
    .inReady (txInReady),
    .outValid(txOutValid),
    .outReady(txPop),
    .outData (txOut),
    .level   (txLevel)
  );

  hut_fifo #(.WIDTH(9), .DEPTH(DEPTH)) rxBuf (
    .clk_sys (clk_sys),
    .reset   (reset),
    .inValid (rxPush),
    .inData  (rxIn),
    .inReady (rxInReady),
    .outValid(rxOutValid),
    .outReady(rxPop),
    .outData (rxOut),
    .level   (rxLevel)
  );

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  // escape END and ESC, send END for a marked word
  wire needEsc = slipEn && !txOut.eof &&
                 (txOut.data == `HUT_CH_END || txOut.data == `HUT_CH_ESC);
  wire [7:0] txPick = txEsc_q ? txEscByte_q :
                      (slipEn && txOut.eof) ? `HUT_CH_END :
                      needEsc ? `HUT_CH_ESC : txOut.data;
  // start at once when clear-to-send and data allow
  wire txGo   = txSt_q == hut_pkg::SER_IDLE && ctsOk && !paused_q &&
                (txEsc_q || txOutValid);
  assign txPop = txGo && !txEsc_q;
  wire txTick = txCnt_q == 16'h0000;

  // start, eight bits LSB first, stop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      txSt_q <= hut_pkg::SER_IDLE;
      txCnt_q <= 16'h0000;
      txBit_q <= 3'h0;
      txSh_q <= 8'h00;
      txd_q <= 1'b1;
      txEsc_q <= 1'b0;
      txEscByte_q <= 8'h00;
    end else begin
      txCnt_q <= txTick ? div_q - 16'h0001 : txCnt_q - 16'h0001;
      case (txSt_q)
        hut_pkg::SER_IDLE: begin
          txCnt_q <= div_q - 16'h0001;
          if (txGo) begin
            txSh_q <= txPick;
            txd_q  <= 1'b0;
            txSt_q <= hut_pkg::SER_START;
            txEsc_q <= needEsc && !txEsc_q;
            txEscByte_q <= (txOut.data == `HUT_CH_END) ? `HUT_CH_ESC_END : `HUT_CH_ESC_ESC;
          end
        end
        hut_pkg::SER_START: if (txTick) begin
          txd_q   <= txSh_q[0];
          txSh_q  <= txSh_q >> 1;
          txBit_q <= 3'h0;
          txSt_q  <= hut_pkg::SER_DATA;
        end
        hut_pkg::SER_DATA: if (txTick) begin
          txBit_q <= txBit_q + 3'h1;
          txd_q   <= (txBit_q == 3'h7) ? 1'b1 : txSh_q[0];
          txSh_q  <= txSh_q >> 1;
          if (txBit_q == 3'h7) txSt_q <= hut_pkg::SER_STOP;
        end
        hut_pkg::SER_STOP: if (txTick) txSt_q <= hut_pkg::SER_IDLE;
        default: txSt_q <= hut_pkg::SER_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------
  wire rxTick = rxCnt_q == 16'h0000;

  // Samples at bit centres; the stop centre delivers the byte
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rxSt_q <= hut_pkg::SER_IDLE;
      rxCnt_q <= 16'h0000;
      rxBit_q <= 3'h0;
      rxSh_q <= 8'h00;
      rxByte_q <= 8'h00;
      rxDone_q <= 1'b0;
    end else begin
      rxDone_q <= 1'b0;
      rxCnt_q  <= rxTick ? div_q - 16'h0001 : rxCnt_q - 16'h0001;
      case (rxSt_q)
        hut_pkg::SER_IDLE: begin
          rxCnt_q <= div_q >> 1;
          if (rxFall && !abArm_q) rxSt_q <= hut_pkg::SER_START;
        end
        hut_pkg::SER_START: if (rxTick) begin
          rxBit_q <= 3'h0;
          rxSt_q  <= rxSync_q ? hut_pkg::SER_IDLE : hut_pkg::SER_DATA;
        end
        hut_pkg::SER_DATA: if (rxTick) begin
          rxSh_q  <= {rxSync_q, rxSh_q[7:1]};
          rxBit_q <= rxBit_q + 3'h1;
          if (rxBit_q == 3'h7) rxSt_q <= hut_pkg::SER_STOP;
        end
        hut_pkg::SER_STOP: if (rxTick) begin
          rxByte_q <= rxSh_q;
          rxDone_q <= rxSync_q;
          rxSt_q   <= hut_pkg::SER_IDLE;
        end
        default: rxSt_q <= hut_pkg::SER_IDLE;
      endcase
    end
  end

  // Flow characters are consumed, SLIP escapes are undone
  // Qualified by the delivery pulse, so a stale byte cannot re-pause
  wire isXon  = rxDone_q && xonEn && rxByte_q == `HUT_CH_XON;
  wire isXoff = rxDone_q && xonEn && rxByte_q == `HUT_CH_XOFF;
  wire isEsc  = slipEn && !rxEsc_q && rxByte_q == `HUT_CH_ESC;
  assign rxPush = rxDone_q && !isXon && !isXoff && !isEsc;
  assign rxIn.eof  = slipEn && !rxEsc_q && rxByte_q == `HUT_CH_END;
  assign rxIn.data = !rxEsc_q ? rxByte_q :
                     (rxByte_q == `HUT_CH_ESC_END) ? `HUT_CH_END :
                     (rxByte_q == `HUT_CH_ESC_ESC) ? `HUT_CH_ESC : rxByte_q;

  // ----------------------------------------------------------------------
  // Flow control, wake and status flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      paused_q <= 1'b0;
      rxEsc_q <= 1'b0;
      rtsN_q <= 1'b1;
      wake_q <= 1'b0;
      overrun_q <= 1'b0;
      rdData_q <= 32'h0000_0000;
      txSpace_q <= 1'b0;
    end else begin
      if (isXoff) paused_q <= 1'b1;
      else if (isXon || !xonEn) paused_q <= 1'b0;
      if (rxDone_q) rxEsc_q <= isEsc;
      rtsN_q <= rxLevel >= RTS_LIM;
      // wake on line activity; a new event beats the clear
      if (sleepEn && (rxFall || ctsChange)) wake_q <= 1'b1;
      else if (wrCtrl && !regWrData[`HUT_CTRL_SLEEP]) wake_q <= 1'b0;
      // Lost byte is sticky; a new loss beats the clearing read
      if (rxPush && !rxInReady) overrun_q <= 1'b1;
      else if (rdStat) overrun_q <= 1'b0;
      rdData_q  <= regRd ? rdMux : 32'h0000_0000;
      txSpace_q <= txInReady;
    end
  end

  assign uartTxd   = txd_q;
  assign uartRtsN  = rtsN_q;
  assign regRdData = rdData_q;
  assign wakeReq   = wake_q;
  assign txSpace   = txSpace_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  rtsFull_a: assert property (rxLevel >= RTS_LIM |=> uartRtsN)
    else $error("request-to-send not dropped when buffer nearly full");
  rtsRoom_a: assert property (rxLevel < RTS_LIM |=> !uartRtsN)
    else $error("request-to-send dropped with room left");
  ctsHold_a: assert property (!threeWire && ctsSync_q && txSt_q == hut_pkg::SER_IDLE
    |=> txSt_q == hut_pkg::SER_IDLE)
    else $error("character started without clear-to-send");
  ctsStart_a: assert property (txGo |=> !uartTxd && txSt_q == hut_pkg::SER_START)
    else $error("start bit late after clear-to-send");
  divRange_a: assert property (div_q >= DIV_MIN && div_q <= DIV_MAX)
    else $error("divider outside line-rate range");
  resetRate_a: assert property ($fell(reset) |-> div_q == DIV_RST)
    else $error("reset line rate wrong");
  xoffPause_a: assert property (isXoff |=> paused_q ##1 !txGo)
    else $error("stop character did not pause");
  wakeRise_a: assert property (sleepEn && rxFall |=> wakeReq)
    else $error("line activity missed while asleep");
  abLoad_a: assert property (abArm_q && abMeas_q && rxRise |=> abDone_q && div_q == $past(abVal))
    else $error("detected rate not loaded");
  stopBit_a: assert property (txSt_q == hut_pkg::SER_STOP |-> uartTxd)
    else $error("stop bit not high");
  slipEsc_a: assert property (txGo && needEsc && !txEsc_q |=> txEsc_q)
    else $error("escape byte not queued");

  txFrame_c: cover property (txSt_q == hut_pkg::SER_STOP ##1 txSt_q == hut_pkg::SER_IDLE);
  rxByte_c:  cover property (rxPush);
  pause_c:   cover property (paused_q ##1 !paused_q);
  abDone_c:  cover property ($rose(abDone_q));
endmodule // hut_uart

// [tb/hut_host_model.sv]
/*
  Host-side UART: frames bytes onto the receive pin and collects the
  bytes framed on the transmit pin. Assumes one bit length in clk_sys cycles.
*/
`timescale 1ns/10ps
module hut_host_model #(
  parameter int BIT = 25
) (
  input  wire logic clk_sys,
  input  wire logic uartTxd,
  output logic      uartRxd
);
  logic [7:0] rxQ[$];
  logic [7:0] sh;
  initial uartRxd = 1'b1;
  // ----------------
  // Transmit side
  // ----------------
  // start, data LSB first, stop, same rate as the device
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      uartRxd <= f[i];
      repeat (BIT) @(posedge clk_sys);
    end
  endtask
  // One bare low pulse, as a rate probe or wake poke
  task automatic pulse(input int n);
    uartRxd <= 1'b0;
    repeat (n) @(posedge clk_sys);
    uartRxd <= 1'b1;
    repeat (BIT) @(posedge clk_sys);
  endtask
  // ----------------
  // Receive side
  // ----------------
  // sample mid-bit; a low stop bit discards the character
  always begin
    @(negedge uartTxd);
    repeat (BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_sys);
      sh[i] = uartTxd;
    end
    repeat (BIT) @(posedge clk_sys);
    if (uartTxd === 1'b1) rxQ.push_back(sh);
  end
endmodule // hut_host_model

// [tb/hut_uart_bench.sv]
/*
  Self-checking bench of the host-link UART, one task per scenario.
  Assumes the host model shares the bit length written to the divider.
*/
`timescale 1ns/10ps
`include "hut_params.svh"
module hut_uart_bench;
  localparam int DEP = 32;
  localparam int BIT = 25;
  logic        clk_sys = 1'b0;
  logic        reset;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic        uartCtsN;
  logic [31:0] regRdData;
  logic [31:0] v;
  logic        uartRxd, uartTxd, uartRtsN, wakeReq, txSpace;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;

  hut_uart #(.DEPTH(DEP)) hut_uart_inst (.clk_sys(clk_sys), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .uartRxd(uartRxd), .uartCtsN(uartCtsN), .uartTxd(uartTxd),
    .uartRtsN(uartRtsN), .wakeReq(wakeReq), .txSpace(txSpace));
  hut_host_model #(.BIT(BIT)) hut_host_model_inst (.clk_sys(clk_sys),
    .uartTxd(uartTxd), .uartRxd(uartRxd));

  // Clock, and a ceiling well above the ~16k cycles the run needs
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      summarize();
    end
  end
  // ----------------
  // Helpers
  // ----------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic waitQ(input int n);
    for (int i = 0; i < 12000 && hut_host_model_inst.rxQ.size() < n; i++)
      @(posedge clk_sys);
  endtask
  function automatic logic [31:0] hq();
    return 32'(hut_host_model_inst.rxQ.pop_front());
  endfunction
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset();
    rd(`HUT_REG_DIV);
    check(v, 32'h0000_0364);
    rd(8'h20);
    check(v, 32'h0000_0000);
    check(32'({uartRtsN, txSpace, wakeReq, uartTxd}), 32'h0000_0005);
  endtask
  task automatic t_div();
    wr(`HUT_REG_DIV, 32'h0000_0005);
    rd(`HUT_REG_DIV);
    check(v, 32'h0000_0019);
    wr(`HUT_REG_DIV, 32'h0000_4E20);
    rd(`HUT_REG_DIV);
    check(v, 32'h0000_28B0);
    wr(`HUT_REG_DIV, 32'h0000_0019);
  endtask
  // Stalled far side: fill until refused, then drain on clear-to-send
  task automatic t_txfill();
    int n;
    // clear-to-send raised while the link is idle
    uartCtsN <= 1'b1;
    for (int i = 0; i <= DEP; i++) wr(`HUT_REG_TXDATA, 32'h0000_0040 + 32'(i));
    repeat (60) @(posedge clk_sys);
    check(32'({txSpace, uartTxd}), 32'h0000_0001);
    rd(`HUT_REG_STATUS);
    check(32'(v[1]), 32'h0000_0001);
    @(posedge clk_sys);
    uartCtsN <= 1'b0;
    for (n = 0; n < 200 && uartTxd; n++) begin
      @(posedge clk_sys);
      #1;
    end
    check(32'(n <= 37), 32'h0000_0001);
    waitQ(DEP);
    repeat (300) @(posedge clk_sys);
    check(32'(hut_host_model_inst.rxQ.size()), 32'(DEP));
    for (int i = 0; i < DEP; i++) check(hq(), 32'h0000_0040 + 32'(i));
  endtask
  task automatic t_rx();
    hut_host_model_inst.send(8'h3C);
    rd(`HUT_REG_RXDATA);
    check(v, 32'h0000_023C);
    rd(`HUT_REG_RXDATA);
    check(v, 32'h0000_0000);
  endtask
  task automatic t_rts();
    for (int i = 0; i < DEP - 16; i++) begin
      hut_host_model_inst.send(8'(i));
      if (i == DEP - 18) check(32'(uartRtsN), 32'h0000_0000);
    end
    check(32'(uartRtsN), 32'h0000_0001);
    rd(`HUT_REG_LEVEL);
    check(32'(v[26:16]), 32'h0000_0010);
    for (int i = 0; i < DEP - 16; i++) begin
      rd(`HUT_REG_RXDATA);
      check(v, 32'h0000_0200 + 32'(i));
    end
    check(32'(uartRtsN), 32'h0000_0000);
  endtask
  task automatic t_xon();
    wr(`HUT_REG_CTRL, 32'h0000_0002);
    hut_host_model_inst.send(8'h13);
    wr(`HUT_REG_TXDATA, 32'h0000_0055);
    repeat (400) @(posedge clk_sys);
    rd(`HUT_REG_STATUS);
    check(32'(v[2:0]), 32'h0000_0004);
    check(32'(hut_host_model_inst.rxQ.size()), 32'h0000_0000);
    hut_host_model_inst.send(8'h11);
    waitQ(1);
    check(hq(), 32'h0000_0055);
    wr(`HUT_REG_CTRL, 32'h0000_0000);
  endtask
  task automatic t_slip();
    wr(`HUT_REG_CTRL, 32'h0000_0004);
    wr(`HUT_REG_TXDATA, 32'h0000_00C0);
    wr(`HUT_REG_TXDATA, 32'h0000_0100);
    waitQ(3);
    check(hq(), 32'h0000_00DB);
    check(hq(), 32'h0000_00DC);
    check(hq(), 32'h0000_00C0);
    hut_host_model_inst.send(8'hDB);
    hut_host_model_inst.send(8'hDD);
    hut_host_model_inst.send(8'hC0);
    rd(`HUT_REG_RXDATA);
    check(v, 32'h0000_02DB);
    rd(`HUT_REG_RXDATA);
    check(v, 32'h0000_03C0);
    wr(`HUT_REG_CTRL, 32'h0000_0000);
  endtask
  task automatic t_three();
    wr(`HUT_REG_CTRL, 32'h0000_0001);
    uartCtsN <= 1'b1;
    wr(`HUT_REG_TXDATA, 32'h0000_005A);
    waitQ(1);
    check(hq(), 32'h0000_005A);
    wr(`HUT_REG_CTRL, 32'h0000_0000);
    uartCtsN <= 1'b0;
  endtask
  task automatic t_baud();
    wr(`HUT_REG_CTRL, 32'h0000_0008);
    rd(`HUT_REG_STATUS);
    check(32'(v[6]), 32'h0000_0001);
    hut_host_model_inst.pulse(40);
    rd(`HUT_REG_DIV);
    check(v, 32'h0000_0028);
    rd(`HUT_REG_STATUS);
    check(32'(v[6:4]), 32'h0000_0001);
    wr(`HUT_REG_DIV, 32'h0000_0019);
  endtask
  // Wake poke last: a bare pulse fails the start-bit check and leaves no byte behind
  task automatic t_wake();
    wr(`HUT_REG_CTRL, 32'h0000_0010);
    uartCtsN <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 check(32'(wakeReq), 32'h0000_0001);
    wr(`HUT_REG_CTRL, 32'h0000_0000);
    uartCtsN <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 check(32'(wakeReq), 32'h0000_0000);
    wr(`HUT_REG_CTRL, 32'h0000_0010);
    hut_host_model_inst.pulse(5);
    check(32'(wakeReq), 32'h0000_0001);
  endtask
  // Main sequence after five cycles of reset
  initial begin
    reset     <= 1'b1;
    regAddr   <= 8'h00;
    regWrData <= 32'h0000_0000;
    regWr     <= 1'b0;
    regRd     <= 1'b0;
    uartCtsN  <= 1'b0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_div();
    t_txfill();
    t_rx();
    t_rts();
    t_xon();
    t_slip();
    t_three();
    t_baud();
    t_wake();
    summarize();
  end
endmodule // hut_uart_bench
